// *** rtl/ctx_sp_consts.svh ***
// Constants for the register bank base and stack top pointer block
// Function
// - Bank base bits 15-12 one, bit 0 zero
// - Written bits 11-9 zero force bits 11-10
// - Bank base addresses first of sixteen registers
// - Short operand: base plus operand, doubled for words
// - Pointer registers word read, 2-bit selects first four
// - Register codes F0-FF map to short operand
// - Bit access: word address plus 4-bit position
// - Next instruction still uses previous bank base
// - Context switch pushes base, loads new, one cycle
// - Both pointers writable through register port
// - Push pre-decrements, pop post-increments stack pointer
// - Stack pointer bit 0 zero, bits 15-12 one
// - Push or subtract below limit raises overflow trap
`ifndef CTX_SP_CONSTS_SVH
`define CTX_SP_CONSTS_SVH

`define CSP_CP_ADDR     16'hFE10
`define CSP_SP_ADDR     16'hFE12
`define CSP_PTR_RESET   16'hFC00
`define CSP_FIXED_ONES  16'hF000
`define CSP_WR_MASK     16'h0FFE
`define CSP_CP_FORCE    16'h0C00
`define CSP_CP_ZCHK     16'h0E00
`define CSP_WORD_STEP   16'h0002
`define CSP_BANK_SPAN   16'h0020
`define CSP_REG8_GPR    4'hF
`define CSP_ZERO16      16'h0000

`endif

// *** rtl/ctx_sp_pkg.sv ***
// Types shared by the pointer block and its address calculator
package ctx_sp_pkg;

    typedef enum logic [2:0] {
        MODE_WORD4,
        MODE_BYTE4,
        MODE_PTR2,
        MODE_REG8W,
        MODE_REG8B,
        MODE_BIT
    } gpr_mode_t;

    typedef struct packed {
        logic       valid;
        gpr_mode_t  mode;
        logic [7:0] operand;
        logic [3:0] bit_sel;
    } gpr_req_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [15:0] addr;
        logic [3:0]  bit_pos;
    } gpr_ans_t;

    typedef struct packed {
        logic        push;
        logic        pop;
        logic        arith;
        logic        sub;
        logic [15:0] delta;
        logic [15:0] push_data;
        logic        ctx_sw;
        logic [15:0] ctx_val;
    } stack_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] data;
    } ram_req_t;

    typedef struct packed {
        logic [15:0] cp;
        logic [15:0] sp;
        logic [15:0] cp_start;
        logic [15:0] cp_gpr;
        logic [15:0] rdata;
        ram_req_t    ram;
        gpr_ans_t    gpr;
        logic        trap;
    } state_t;

endpackage : ctx_sp_pkg

// *** rtl/gpr_addr_calc.sv ***
// Physical general register address from short operands
`timescale 1ns/1ns
`include "ctx_sp_consts.svh"
module gpr_addr_calc (
    input  wire logic [15:0]       bank_base_i,
    input  ctx_sp_pkg::gpr_req_t   req_i,
    output ctx_sp_pkg::gpr_ans_t   ans_o
);
    logic [15:0] offs;
    logic        is_gpr;

    always_comb begin
        offs   = `CSP_ZERO16;
        is_gpr = 1'b1;
        unique case (req_i.mode)
            ctx_sp_pkg::MODE_WORD4: begin
                offs = {11'h000, req_i.operand[3:0], 1'b0};
            end
            ctx_sp_pkg::MODE_BYTE4: begin
                offs = {12'h000, req_i.operand[3:0]};
            end
            ctx_sp_pkg::MODE_PTR2: begin
                offs = {13'h0000, req_i.operand[1:0], 1'b0};
            end
            ctx_sp_pkg::MODE_REG8B: begin
                is_gpr = (req_i.operand[7:4] == `CSP_REG8_GPR);
                offs   = {12'h000, req_i.operand[3:0]};
            end
            ctx_sp_pkg::MODE_REG8W,
            ctx_sp_pkg::MODE_BIT: begin
                is_gpr = (req_i.operand[7:4] == `CSP_REG8_GPR);
                offs   = {11'h000, req_i.operand[3:0], 1'b0};
            end
            default: begin
                is_gpr = 1'b0;
            end
        endcase
        ans_o.valid   = req_i.valid;
        ans_o.hit     = is_gpr;
        ans_o.addr    = bank_base_i + offs;
        ans_o.bit_pos = (req_i.mode == ctx_sp_pkg::MODE_BIT)
                      ? req_i.bit_sel : 4'h0;
    end
endmodule : gpr_addr_calc

// *** rtl/context_and_stack_pointer.sv ***
// Register bank base and stack top pointers with stack moves
`timescale 1ns/1ns
`include "ctx_sp_consts.svh"
module context_and_stack_pointer (
    input  wire logic                    clk_sys_i,
    input  wire logic                    reset_n_i,
    input  wire logic [15:0]             bus_addr_i,
    input  wire logic [15:0]             bus_wdata_i,
    input  wire logic                    bus_wr_i,
    input  wire logic                    bus_rd_i,
    output logic      [15:0]             bus_rdata_o,
    input  wire logic                    instr_next_i,
    input  ctx_sp_pkg::gpr_req_t         gpr_req_i,
    output ctx_sp_pkg::gpr_ans_t         gpr_ans_o,
    input  ctx_sp_pkg::stack_req_t       stack_req_i,
    input  wire logic [15:0]             stack_limit_i,
    output ctx_sp_pkg::ram_req_t         ram_req_o,
    output logic                         ovf_trap_o,
    output logic      [15:0]             register_bank_base_o,
    output logic      [15:0]             stack_top_pointer_o
);

    // ==========================================================
    // Write shaping
    // ==========================================================
    function automatic logic [15:0] bank_base_wr(input logic [15:0] v);
        logic [15:0] r;
        r = `CSP_FIXED_ONES | (v & `CSP_WR_MASK);
        if ((v & `CSP_CP_ZCHK) == `CSP_ZERO16) begin
            r = r | `CSP_CP_FORCE;
        end
        return r;
    endfunction : bank_base_wr

    function automatic logic [15:0] stack_fix(input logic [15:0] v);
        return `CSP_FIXED_ONES | (v & `CSP_WR_MASK);
    endfunction : stack_fix

    // ==========================================================
    // State
    // ==========================================================
    ctx_sp_pkg::state_t   st_r;
    ctx_sp_pkg::state_t   st_nxt;
    ctx_sp_pkg::gpr_ans_t gpr_calc;
    logic [15:0]          sp_moved;
    logic                 sp_check;

    // ==========================================================
    // Address calculator
    // ==========================================================
    gpr_addr_calc u_gpr_addr_calc (
        .bank_base_i (st_r.cp_gpr),
        .req_i       (gpr_req_i),
        .ans_o       (gpr_calc)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_nxt           = st_r;
        st_nxt.rdata     = `CSP_ZERO16;
        st_nxt.ram       = '0;
        st_nxt.trap      = 1'b0;
        st_nxt.gpr       = gpr_calc;
        sp_moved         = st_r.sp;
        sp_check         = 1'b0;

        // Register port, lowest priority
        if (bus_rd_i) begin
            if (bus_addr_i == `CSP_CP_ADDR) begin
                st_nxt.rdata = st_r.cp;
            end else if (bus_addr_i == `CSP_SP_ADDR) begin
                st_nxt.rdata = st_r.sp;
            end
        end
        if (bus_wr_i) begin
            if (bus_addr_i == `CSP_CP_ADDR) begin
                st_nxt.cp = bank_base_wr(bus_wdata_i);
            end else if (bus_addr_i == `CSP_SP_ADDR) begin
                st_nxt.sp = stack_fix(bus_wdata_i);
            end
        end

        // Stack moves override a same-cycle port write
        if (stack_req_i.ctx_sw) begin
            sp_moved       = stack_fix(st_r.sp - `CSP_WORD_STEP);
            st_nxt.sp      = sp_moved;
            st_nxt.cp      = bank_base_wr(stack_req_i.ctx_val);
            st_nxt.ram     = '{valid: 1'b1, write: 1'b1,
                               addr: sp_moved, data: st_r.cp};
            sp_check       = 1'b1;
        end else if (stack_req_i.push) begin
            sp_moved       = stack_fix(st_r.sp - `CSP_WORD_STEP);
            st_nxt.sp      = sp_moved;
            st_nxt.ram     = '{valid: 1'b1, write: 1'b1,
                               addr: sp_moved,
                               data: stack_req_i.push_data};
            sp_check       = 1'b1;
        end else if (stack_req_i.pop) begin
            st_nxt.ram     = '{valid: 1'b1, write: 1'b0,
                               addr: st_r.sp, data: `CSP_ZERO16};
            st_nxt.sp      = stack_fix(st_r.sp + `CSP_WORD_STEP);
        end else if (stack_req_i.arith) begin
            if (stack_req_i.sub) begin
                sp_moved   = stack_fix(st_r.sp - stack_req_i.delta);
                sp_check   = 1'b1;
            end else begin
                sp_moved   = stack_fix(st_r.sp + stack_req_i.delta);
            end
            st_nxt.sp      = sp_moved;
        end

        st_nxt.trap = sp_check && (sp_moved < stack_limit_i);

        // Base pointer seen by address math lags one instruction
        if (instr_next_i) begin
            st_nxt.cp_start = st_r.cp;
            st_nxt.cp_gpr   = st_r.cp_start;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r.cp       <= `CSP_PTR_RESET;
            st_r.sp       <= `CSP_PTR_RESET;
            st_r.cp_start <= `CSP_PTR_RESET;
            st_r.cp_gpr   <= `CSP_PTR_RESET;
            st_r.rdata    <= `CSP_ZERO16;
            st_r.ram      <= '0;
            st_r.gpr      <= '0;
            st_r.trap     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign bus_rdata_o          = st_r.rdata;
    assign gpr_ans_o            = st_r.gpr;
    assign ram_req_o            = st_r.ram;
    assign ovf_trap_o           = st_r.trap;
    assign register_bank_base_o = st_r.cp;
    assign stack_top_pointer_o  = st_r.sp;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    logic ctx_idle;
    assign ctx_idle = !stack_req_i.ctx_sw && !stack_req_i.push
                   && !stack_req_i.pop && !stack_req_i.arith;

    cp_fixed_bits_a: assert property (
        st_r.cp[15:12] == 4'hF && st_r.cp[0] == 1'b0)
        else $error("bank base fixed bits wrong");

    cp_force_a: assert property (
        bus_wr_i && bus_addr_i == `CSP_CP_ADDR && !stack_req_i.ctx_sw
        && (bus_wdata_i & `CSP_CP_ZCHK) == `CSP_ZERO16
        |=> st_r.cp[11:10] == 2'b11 && st_r.cp[9] == 1'b0)
        else $error("bank base force bits missing");

    cp_plain_a: assert property (
        bus_wr_i && bus_addr_i == `CSP_CP_ADDR && !stack_req_i.ctx_sw
        && (bus_wdata_i & `CSP_CP_ZCHK) != `CSP_ZERO16
        |=> st_r.cp == (`CSP_FIXED_ONES
                       | ($past(bus_wdata_i) & `CSP_WR_MASK)))
        else $error("bank base write value wrong");

    gpr_word_a: assert property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_WORD4
        |=> gpr_ans_o.valid && gpr_ans_o.addr == $past(st_r.cp_gpr)
            + {11'h000, $past(gpr_req_i.operand[3:0]), 1'b0})
        else $error("word register address wrong");

    reg8_miss_a: assert property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_REG8W
        && gpr_req_i.operand[7:4] != `CSP_REG8_GPR
        |=> !gpr_ans_o.hit)
        else $error("register code outside range taken");

    sp_fixed_bits_a: assert property (
        st_r.sp[15:12] == 4'hF && st_r.sp[0] == 1'b0)
        else $error("stack pointer fixed bits wrong");

    push_dec_a: assert property (
        stack_req_i.push && !stack_req_i.ctx_sw
        |=> st_r.sp == stack_fix($past(st_r.sp) - `CSP_WORD_STEP)
            && ram_req_o.write && ram_req_o.addr == st_r.sp)
        else $error("push did not pre-decrement");

    pop_inc_a: assert property (
        stack_req_i.pop && !stack_req_i.push && !stack_req_i.ctx_sw
        |=> ram_req_o.valid && !ram_req_o.write
            && ram_req_o.addr == $past(st_r.sp)
            && st_r.sp == stack_fix(ram_req_o.addr + `CSP_WORD_STEP))
        else $error("pop did not post-increment");

    ctx_switch_a: assert property (
        stack_req_i.ctx_sw
        |=> ram_req_o.write && ram_req_o.data == $past(st_r.cp)
            && st_r.cp == bank_base_wr($past(stack_req_i.ctx_val)))
        else $error("context switch wrong");

    ovf_trap_a: assert property (
        (stack_req_i.push || stack_req_i.ctx_sw)
        |=> ovf_trap_o == (st_r.sp < $past(stack_limit_i)))
        else $error("overflow trap wrong");

    no_trap_idle_a: assert property (
        ctx_idle |=> !ovf_trap_o)
        else $error("trap without stack move");

    cp_lag_a: assert property (
        instr_next_i
        |=> st_r.cp_start == $past(st_r.cp)
            && st_r.cp_gpr == $past(st_r.cp_start))
        else $error("address base not lagging");

    reg_byte_a: assert property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_BYTE4
        |=> gpr_ans_o.hit && gpr_ans_o.addr == $past(st_r.cp_gpr)
            + {12'h000, $past(gpr_req_i.operand[3:0])})
        else $error("byte register address wrong");

    reg_pointer_a: assert property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_PTR2
        |=> gpr_ans_o.hit && gpr_ans_o.addr == $past(st_r.cp_gpr)
            + {13'h0000, $past(gpr_req_i.operand[1:0]), 1'b0})
        else $error("pointer register address wrong");

    reg8_hit_a: assert property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_REG8W
        && gpr_req_i.operand[7:4] == `CSP_REG8_GPR
        |=> gpr_ans_o.hit && gpr_ans_o.addr == $past(st_r.cp_gpr)
            + {11'h000, $past(gpr_req_i.operand[3:0]), 1'b0})
        else $error("register code in range missed");

    reg8_byte_a: assert property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_REG8B
        |=> gpr_ans_o.hit == ($past(gpr_req_i.operand[7:4])
                              == `CSP_REG8_GPR)
            && gpr_ans_o.addr == $past(st_r.cp_gpr)
            + {12'h000, $past(gpr_req_i.operand[3:0])})
        else $error("byte register code wrong");

    bit_pos_a: assert property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_BIT
        |=> gpr_ans_o.bit_pos == $past(gpr_req_i.bit_sel)
            && gpr_ans_o.hit == ($past(gpr_req_i.operand[7:4])
                                 == `CSP_REG8_GPR)
            && gpr_ans_o.addr == $past(st_r.cp_gpr)
            + {11'h000, $past(gpr_req_i.operand[3:0]), 1'b0})
        else $error("bit access address wrong");

    bit_zero_a: assert property (
        gpr_req_i.mode != ctx_sp_pkg::MODE_BIT
        |=> gpr_ans_o.bit_pos == 4'h0)
        else $error("bit position outside bit access");

    bank_span_a: assert property (
        gpr_req_i.valid
        |=> gpr_ans_o.addr - $past(st_r.cp_gpr) < `CSP_BANK_SPAN)
        else $error("register address outside bank");

    answer_valid_a: assert property (
        gpr_ans_o.valid == $past(gpr_req_i.valid))
        else $error("address answer valid wrong");

    read_base_a: assert property (
        bus_rd_i && bus_addr_i == `CSP_CP_ADDR
        |=> bus_rdata_o == $past(st_r.cp))
        else $error("bank base read wrong");

    read_stack_a: assert property (
        bus_rd_i && bus_addr_i == `CSP_SP_ADDR
        |=> bus_rdata_o == $past(st_r.sp))
        else $error("stack pointer read wrong");

    read_idle_a: assert property (
        !(bus_rd_i && (bus_addr_i == `CSP_CP_ADDR
                       || bus_addr_i == `CSP_SP_ADDR))
        |=> bus_rdata_o == `CSP_ZERO16)
        else $error("read data outside read cycle");

    stack_write_a: assert property (
        bus_wr_i && bus_addr_i == `CSP_SP_ADDR && ctx_idle
        |=> st_r.sp == stack_fix($past(bus_wdata_i)))
        else $error("stack pointer write lost");

    base_hold_a: assert property (
        !stack_req_i.ctx_sw && !(bus_wr_i && bus_addr_i == `CSP_CP_ADDR)
        |=> $stable(st_r.cp))
        else $error("bank base changed unasked");

    stack_hold_a: assert property (
        ctx_idle && !(bus_wr_i && bus_addr_i == `CSP_SP_ADDR)
        |=> $stable(st_r.sp))
        else $error("stack pointer changed unasked");

    addr_base_hold_a: assert property (
        !instr_next_i |=> $stable(st_r.cp_gpr))
        else $error("address base moved between instructions");

    push_data_a: assert property (
        stack_req_i.push && !stack_req_i.ctx_sw
        |=> ram_req_o.valid
            && ram_req_o.data == $past(stack_req_i.push_data))
        else $error("push data wrong");

    ctx_push_a: assert property (
        stack_req_i.ctx_sw
        |=> ram_req_o.valid && ram_req_o.addr == st_r.sp
            && st_r.sp == stack_fix($past(st_r.sp) - `CSP_WORD_STEP))
        else $error("context switch push address wrong");

    ram_idle_a: assert property (
        ctx_idle |=> !ram_req_o.valid)
        else $error("memory access without stack move");

    ram_window_a: assert property (
        ram_req_o.valid
        |-> ram_req_o.addr[15:12] == 4'hF && ram_req_o.addr[0] == 1'b0)
        else $error("stack access outside window");

    sub_trap_a: assert property (
        stack_req_i.arith && stack_req_i.sub && !stack_req_i.push
        && !stack_req_i.pop && !stack_req_i.ctx_sw
        |=> st_r.sp == stack_fix($past(st_r.sp) - $past(stack_req_i.delta))
            && ovf_trap_o == (st_r.sp < $past(stack_limit_i)))
        else $error("subtraction trap wrong");

    add_no_trap_a: assert property (
        (stack_req_i.pop || (stack_req_i.arith && !stack_req_i.sub))
        && !stack_req_i.push && !stack_req_i.ctx_sw
        |=> !ovf_trap_o)
        else $error("trap after pop or addition");

    cover_push_c: cover property (stack_req_i.push ##1 stack_req_i.pop);
    cover_sub_c:  cover property (stack_req_i.arith && stack_req_i.sub);
    cover_ctx_c:  cover property (stack_req_i.ctx_sw);
    cover_trap_c: cover property (ovf_trap_o);
    cover_bit_c:  cover property (
        gpr_req_i.valid && gpr_req_i.mode == ctx_sp_pkg::MODE_BIT);

endmodule : context_and_stack_pointer

// *** tb/ram_model.sv ***
// Internal RAM model behind the stack port
`timescale 1ns/1ns
module ram_model (
    input  wire logic            clk_sys_i,
    input  ctx_sp_pkg::ram_req_t req_i,
    output logic      [15:0]     rd_data_o
);
    logic [15:0] mem_r [0:2047];

    // ========================================
    // Word store for the F000-FFFE window
    always_ff @(posedge clk_sys_i) begin
        if (req_i.valid && req_i.write) begin
            mem_r[req_i.addr[11:1]] <= req_i.data;
        end
        if (req_i.valid && !req_i.write) begin
            rd_data_o <= mem_r[req_i.addr[11:1]];
        end else begin
            rd_data_o <= ~rd_data_o;
        end
    end
endmodule : ram_model

// *** tb/tb_top.sv ***
// Self-checking bench for the pointer block
`timescale 1ns/1ns
module tb_top;
    logic                   clk_sys_i;
    logic                   reset_n_i;
    logic [15:0]            bus_addr_i;
    logic [15:0]            bus_wdata_i;
    logic                   bus_wr_i;
    logic                   bus_rd_i;
    logic [15:0]            bus_rdata_o;
    logic                   instr_next_i;
    ctx_sp_pkg::gpr_req_t   gpr_req_i;
    ctx_sp_pkg::gpr_ans_t   gpr_ans_o;
    ctx_sp_pkg::stack_req_t stack_req_i;
    logic [15:0]            stack_limit_i;
    ctx_sp_pkg::ram_req_t   ram_req_o;
    logic                   ovf_trap_o;
    logic [15:0]            bank_base;
    logic [15:0]            stack_top;
    logic [15:0]            ram_rd;
    int                     err_count = 0;
    int                     cmp_count = 0;
    int                     cyc = 0;

    context_and_stack_pointer dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
        .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
        .bus_rdata_o(bus_rdata_o), .instr_next_i(instr_next_i),
        .gpr_req_i(gpr_req_i), .gpr_ans_o(gpr_ans_o),
        .stack_req_i(stack_req_i), .stack_limit_i(stack_limit_i),
        .ram_req_o(ram_req_o), .ovf_trap_o(ovf_trap_o),
        .register_bank_base_o(bank_base), .stack_top_pointer_o(stack_top)
    );

    ram_model ram (
        .clk_sys_i(clk_sys_i), .req_i(ram_req_o), .rd_data_o(ram_rd)
    );

    // ========================================
    // Clock and hang guard
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end

    // ========================================
    // Tasks
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        cmp_count++;
        if (a !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        bus_addr_i  <= a;
        bus_wdata_i <= d;
        bus_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        bus_wr_i    <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        bus_addr_i <= a;
        bus_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        bus_rd_i   <= 1'b0;
        #1;
        chk(e, bus_rdata_o);
        @(posedge clk_sys_i);
        #1;
        chk(16'h0000, bus_rdata_o);
    endtask : rdchk

    task automatic wrchk(input logic [15:0] a, input logic [15:0] d,
                         input logic [15:0] e);
        wr(a, d);
        rdchk(a, e);
    endtask : wrchk

    task automatic step();
        @(posedge clk_sys_i);
        instr_next_i <= 1'b1;
        @(posedge clk_sys_i);
        instr_next_i <= 1'b0;
    endtask : step

    task automatic reg_addr(input ctx_sp_pkg::gpr_mode_t m,
                            input logic [7:0] op, input logic [3:0] bs,
                            input logic [15:0] ea, input logic eh);
        @(posedge clk_sys_i);
        gpr_req_i <= '{1'b1, m, op, bs};
        @(posedge clk_sys_i);
        gpr_req_i <= '0;
        #1;
        chk(16'h0001, {15'h0000, gpr_ans_o.valid});
        chk({15'h0000, eh}, {15'h0000, gpr_ans_o.hit});
        if (eh) begin
            chk(ea, gpr_ans_o.addr);
        end
        chk({12'h000, (m == ctx_sp_pkg::MODE_BIT) ? bs : 4'h0},
            {12'h000, gpr_ans_o.bit_pos});
    endtask : reg_addr

    // Kinds: 0 push, 1 pop, 2 add, 3 subtract, 4 context switch
    task automatic stk(input int k, input logic [15:0] d,
                       input logic [15:0] top, input logic ev,
                       input logic w, input logic [15:0] a,
                       input logic [15:0] dat, input logic trap);
        ctx_sp_pkg::stack_req_t r;
        r = '0;
        r.push = (k == 0);
        r.pop = (k == 1);
        r.arith = (k == 2) || (k == 3);
        r.sub = (k == 3);
        r.ctx_sw = (k == 4);
        r.delta = d;
        r.push_data = d;
        r.ctx_val = d;
        @(posedge clk_sys_i);
        stack_req_i <= r;
        @(posedge clk_sys_i);
        stack_req_i <= '0;
        #1;
        chk(top, stack_top);
        chk({15'h0000, ev}, {15'h0000, ram_req_o.valid});
        if (ev) begin
            chk({15'h0000, w}, {15'h0000, ram_req_o.write});
            chk(a, ram_req_o.addr);
            if (w) begin
                chk(dat, ram_req_o.data);
            end
        end
        chk({15'h0000, trap}, {15'h0000, ovf_trap_o});
    endtask : stk

    // ========================================
    // Main sequence
    initial begin
        reset_n_i     = 1'b0;
        bus_addr_i    = 16'h0000;
        bus_wdata_i   = 16'h0000;
        bus_wr_i      = 1'b0;
        bus_rd_i      = 1'b0;
        instr_next_i  = 1'b0;
        gpr_req_i     = '0;
        stack_req_i   = '0;
        stack_limit_i = 16'hF000;
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        #1;
        chk(16'hFC00, bank_base);
        chk(16'hFC00, stack_top);
        rdchk(16'hFE10, 16'hFC00);
        rdchk(16'hFE12, 16'hFC00);
        $display("test reset done");

        wrchk(16'hFE10, 16'h0000, 16'hFC00);
        wrchk(16'hFE10, 16'h1234, 16'hF234);
        wrchk(16'hFE10, 16'h01FF, 16'hFDFE);
        wrchk(16'hFE10, 16'hFFFF, 16'hFFFE);
        wrchk(16'hFE12, 16'hFFFF, 16'hFFFE);
        wrchk(16'hFE12, 16'h0001, 16'hF000);
        wrchk(16'hFE12, 16'h0E01, 16'hFE00);
        wr(16'hFE14, 16'h1234);
        rdchk(16'hFE14, 16'h0000);
        rdchk(16'hFE10, 16'hFFFE);
        $display("test registers done");

        wr(16'hFE10, 16'hFA00);
        step();
        reg_addr(ctx_sp_pkg::MODE_WORD4, 8'h03, 4'h0, 16'hFC06, 1'b1);
        step();
        reg_addr(ctx_sp_pkg::MODE_WORD4, 8'h03, 4'h0, 16'hFA06, 1'b1);
        reg_addr(ctx_sp_pkg::MODE_WORD4, 8'h0F, 4'h0, 16'hFA1E, 1'b1);
        reg_addr(ctx_sp_pkg::MODE_BYTE4, 8'h05, 4'h0, 16'hFA05, 1'b1);
        reg_addr(ctx_sp_pkg::MODE_PTR2, 8'h07, 4'h0, 16'hFA06, 1'b1);
        reg_addr(ctx_sp_pkg::MODE_REG8W, 8'hF2, 4'h0, 16'hFA04, 1'b1);
        reg_addr(ctx_sp_pkg::MODE_REG8B, 8'hF3, 4'h0, 16'hFA03, 1'b1);
        reg_addr(ctx_sp_pkg::MODE_REG8W, 8'hE2, 4'h0, 16'h0000, 1'b0);
        reg_addr(ctx_sp_pkg::MODE_BIT, 8'hF1, 4'h9, 16'hFA02, 1'b1);
        $display("test register addressing done");

        wr(16'hFE12, 16'hF100);
        @(posedge clk_sys_i);
        stk(0, 16'hA5A5, 16'hF0FE, 1, 1, 16'hF0FE, 16'hA5A5, 0);
        stk(1, 16'h0000, 16'hF100, 1, 0, 16'hF0FE, 16'h0000, 0);
        @(posedge clk_sys_i);
        #1;
        chk(16'hA5A5, ram_rd);
        stack_limit_i <= 16'hF100;
        stk(0, 16'h1111, 16'hF0FE, 1, 1, 16'hF0FE, 16'h1111, 1);
        stk(2, 16'h0002, 16'hF100, 0, 0, 16'h0000, 16'h0000, 0);
        stk(3, 16'h0004, 16'hF0FC, 0, 0, 16'h0000, 16'h0000, 1);
        stk(2, 16'h0004, 16'hF100, 0, 0, 16'h0000, 16'h0000, 0);
        stack_limit_i <= 16'hF000;
        stk(4, 16'h0000, 16'hF0FE, 1, 1, 16'hF0FE, 16'hFA00, 0);
        chk(16'hFC00, bank_base);
        $display("test stack done");
        finish_test();
    end
endmodule : tb_top
